// ---- common/src_pkg.sv ----
// shared constants for the system reset controller
package src_pkg;
  // reset cause register bit positions
  localparam int CAUSE_POR = 0;
  localparam int CAUSE_PIN = 1;
  localparam int CAUSE_WDT = 2;
  localparam int CAUSE_LVR = 3;
  localparam int CAUSE_BOD = 4;
  localparam int CAUSE_SYS = 5;
  localparam int CAUSE_CPU = 7;
  localparam int CAUSE_LOCK = 8;
  localparam int CAUSE_W = 9;
  localparam logic [8:0] CAUSE_USED = 9'h1_BF;
  // software reset control bits
  localparam int SWR_CHIP = 0;
  localparam int SWR_CORE = 1;
  // core interrupt/reset control bit
  localparam int AIRC_SYSREQ = 2;
  // brown-out control register fields
  localparam int BODC_EN = 0;
  localparam int BODC_RSTEN = 3;
  localparam int BODC_LOW_VOLTAGE_RESET_ENABLE = 7;
  localparam int BODC_BDG_LO = 8;
  localparam int BODC_LDG_LO = 12;
  localparam int BODC_VL_LO = 16;
  localparam logic [31:0] BODC_RST = 32'h0000_0080;
  // user configuration word fields
  localparam int CFG_BROWNOUT_ENABLE = 19;
  localparam int CFG_BORST = 20;
  localparam int CFG_BOV_LO = 21;
  localparam int CFG_BS = 1;
  // timing at 25 MHz
  localparam int CLK_MHZ = 25;
  localparam int PIN_FILT_US = 32;
  localparam int PIN_FILT_CYC = PIN_FILT_US * CLK_MHZ;
  // deglitch select: 0 = off, n = 2^(n+3) cycles
  localparam int DG_BASE_LOG2 = 3;
  // clock settings reloaded by reset
  localparam logic [2:0] CLKSEL_RST = 3'h5;
  localparam logic [3:0] CLKDIV_RST = 4'h0;
  localparam logic [3:0] CLKDIV_SOFT = 4'h3;
endpackage

// ---- design/src_filter.sv ----
// persistence filter: output follows input after it holds for a time
`timescale 1ns/1ps
module src_filter #(
  parameter int CW = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic init_val,
  input wire logic in_lvl,
  input wire logic bypass,
  input wire logic [CW-1:0] limit,
  output logic out_lvl
);
  logic out_q;
  logic [CW-1:0] cnt_q;
  wire logic differ = (in_lvl != out_q);
  wire logic done = (cnt_q >= limit);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_q <= init_val;
      cnt_q <= '0;
    end else if (!differ) begin
      cnt_q <= '0;
    end else if (bypass || done) begin
      out_q <= in_lvl;
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end
  assign out_lvl = out_q;
endmodule

// ---- design/src_reset_ctrl.sv ----
// system reset controller: sources, filters, hold, cause flags, reloads
`timescale 1ns/1ps
// Operation
// - each source sets its own cause bit, except chip reset, which sets the power-on bit
// - core-only reset spares peripherals; others reset all
// - pin low over filter time asserts reset
// - hold reset until pin high over filter
// - hold reset until core supply ready; flag
// - power-on flag cleared by writing one
// - enabled low-voltage persisting past deglitch resets
// - low-voltage absent past deglitch before release
// - low-voltage reset enabled, deglitch off, at reset
// - enabled brown-out persisting past deglitch resets
// - brown-out absent past deglitch before release
// - brown-out defaults load from configuration word
// - core lockup raises a lockup reset
// - lockup ignored while in debug mode
// - core-reset bit resets only the core
// - chip-reset bit acts like power-on reset
// - chip reset reloads boot select from config
// - system request resets, keeps boot select
// - unaffected registers keep value through reset
module src_reset_ctrl #(
  parameter int PIN_CYC = src_pkg::PIN_FILT_CYC,
  parameter int CW = 16,
  parameter int HOLD_CYC = 16
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic supply_ready,
  input wire logic external_reset_pin_n,
  input wire logic watchdog_reset,
  input wire logic low_voltage_ind,
  input wire logic brownout_ind,
  input wire logic core_lockup,
  input wire logic debug_mode,
  input wire logic [31:0] user_configuration_word,
  input wire logic [31:0] software_reset_control_wdata,
  input wire logic software_reset_control_we,
  input wire logic [31:0] core_interrupt_reset_control_wdata,
  input wire logic core_interrupt_reset_control_we,
  input wire logic [31:0] brownout_control_wdata,
  input wire logic brownout_control_we,
  input wire logic [8:0] cause_clear_wdata,
  input wire logic cause_clear_we,
  input wire logic boot_select_wdata,
  input wire logic boot_select_we,
  output logic core_reset,
  output logic periph_reset,
  output logic [8:0] reset_cause_register,
  output logic [31:0] software_reset_control,
  output logic [31:0] brownout_control_register,
  output logic [2:0] brownout_level_select,
  output logic boot_select,
  output logic [2:0] system_clock_source_select,
  output logic [3:0] system_clock_divider
);
  typedef enum logic [1:0] {SRC_RUN, SRC_HOLD, SRC_WAIT} src_state_t;

  // two-flop synchronisers for pin and analog indications
  logic [1:0] pin_s_q, ok_s_q, lv_s_q, bod_s_q, wd_s_q, lk_s_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_s_q <= 2'h3;
      ok_s_q <= 2'h0;
      lv_s_q <= 2'h0;
      bod_s_q <= 2'h0;
      wd_s_q <= 2'h0;
      lk_s_q <= 2'h0;
    end else begin
      pin_s_q <= {pin_s_q[0], external_reset_pin_n};
      ok_s_q <= {ok_s_q[0], supply_ready};
      lv_s_q <= {lv_s_q[0], low_voltage_ind};
      bod_s_q <= {bod_s_q[0], brownout_ind};
      wd_s_q <= {wd_s_q[0], watchdog_reset};
      lk_s_q <= {lk_s_q[0], core_lockup};
    end
  end

  logic [31:0] bodc_q, bodc_d;
  wire logic lvr_en = bodc_q[src_pkg::BODC_LOW_VOLTAGE_RESET_ENABLE];
  wire logic bod_en = bodc_q[src_pkg::BODC_EN];
  wire logic bod_rsten = bodc_q[src_pkg::BODC_RSTEN];
  wire logic [2:0] lvr_dg = bodc_q[src_pkg::BODC_LDG_LO +: 3];
  wire logic [2:0] bod_dg = bodc_q[src_pkg::BODC_BDG_LO +: 3];
  wire logic [CW-1:0] lvr_lim =
    CW'((32'd1 << (lvr_dg + src_pkg::DG_BASE_LOG2)) - 1);
  wire logic [CW-1:0] bod_lim =
    CW'((32'd1 << (bod_dg + src_pkg::DG_BASE_LOG2)) - 1);
  wire logic [CW-1:0] pin_lim = CW'(PIN_CYC);

  logic pin_low, lv_f, bod_f;
  // pin low/high must each persist past the glitch time
  src_filter #(.CW(CW)) u_pin (
    .clk(clk),
    .sys_rst(sys_rst),
    .init_val(1'b0),
    .in_lvl(~pin_s_q[1]),
    .bypass(1'b0),
    .limit(pin_lim),
    .out_lvl(pin_low)
  );
  src_filter #(.CW(CW)) u_lvr (
    .clk(clk),
    .sys_rst(sys_rst),
    .init_val(1'b0),
    .in_lvl(lv_s_q[1] & lvr_en),
    .bypass(lvr_dg == 3'h0),
    .limit(lvr_lim),
    .out_lvl(lv_f)
  );
  src_filter #(.CW(CW)) u_bod (
    .clk(clk),
    .sys_rst(sys_rst),
    .init_val(1'b0),
    .in_lvl(bod_s_q[1] & bod_en),
    .bypass(bod_dg == 3'h0),
    .limit(bod_lim),
    .out_lvl(bod_f)
  );

  // level-type sources hold reset while active
  wire logic por_act = ~ok_s_q[1];
  wire logic lvr_act = lv_f;
  wire logic bod_act = bod_f & bod_rsten;
  wire logic lock_ev = lk_s_q[1] & ~debug_mode;
  wire logic chip_ev = software_reset_control_we &
    software_reset_control_wdata[src_pkg::SWR_CHIP];
  wire logic core_ev = software_reset_control_we &
    software_reset_control_wdata[src_pkg::SWR_CORE];
  wire logic sys_ev = core_interrupt_reset_control_we &
    core_interrupt_reset_control_wdata[src_pkg::AIRC_SYSREQ];
  wire logic wdt_ev = wd_s_q[1];

  logic [8:0] ev;
  always_comb begin
    ev = '0;
    ev[src_pkg::CAUSE_POR] = por_act | chip_ev;
    ev[src_pkg::CAUSE_PIN] = pin_low;
    ev[src_pkg::CAUSE_WDT] = wdt_ev;
    ev[src_pkg::CAUSE_LVR] = lvr_act;
    ev[src_pkg::CAUSE_BOD] = bod_act;
    ev[src_pkg::CAUSE_SYS] = sys_ev;
    ev[src_pkg::CAUSE_CPU] = core_ev;
    ev[src_pkg::CAUSE_LOCK] = lock_ev;
  end
  wire logic full_lvl = por_act | pin_low | lvr_act | bod_act;
  wire logic full_pulse = wdt_ev | lock_ev | chip_ev | sys_ev;
  wire logic full_any = full_lvl | full_pulse;
  // reloads: a full reset that is not the system request is a chip reset
  wire logic chip_class = full_lvl | wdt_ev | lock_ev | chip_ev;
  wire logic bod_reload = chip_class & ~bod_act | sys_ev;
  wire logic div3_src = lock_ev | sys_ev;

  src_state_t st_q, st_d;
  logic [7:0] hold_q, hold_d;
  logic core_only_q, core_only_d;
  always_comb begin
    st_d = st_q;
    hold_d = hold_q;
    core_only_d = core_only_q;
    unique case (st_q)
      SRC_RUN: begin
        if (full_any) begin
          st_d = SRC_HOLD;
          core_only_d = 1'b0;
          hold_d = 8'(HOLD_CYC);
        end else if (core_ev) begin
          st_d = SRC_HOLD;
          core_only_d = 1'b1;
          hold_d = 8'(HOLD_CYC);
        end
      end
      SRC_HOLD: begin
        if (full_any) begin
          core_only_d = 1'b0;
        end
        // short pulse sources get a fixed hold; levels stretch it
        if (full_lvl) begin
          hold_d = 8'(HOLD_CYC);
        end else if (hold_q != 8'h00) begin
          hold_d = hold_q - 8'h01;
        end else begin
          st_d = SRC_WAIT;
        end
      end
      SRC_WAIT: begin
        st_d = full_any ? SRC_HOLD : SRC_RUN;
        hold_d = 8'(HOLD_CYC);
      end
    endcase
  end

  logic [8:0] cause_q, cause_d;
  always_comb begin
    // set wins over a simultaneous write-one clear
    cause_d = cause_q;
    if (cause_clear_we) begin
      cause_d = cause_q & ~cause_clear_wdata;
    end
    cause_d = (cause_d | ev) & src_pkg::CAUSE_USED;
  end

  always_comb begin
    bodc_d = bodc_q;
    if (brownout_control_we) begin
      bodc_d = brownout_control_wdata;
    end
    if (bod_reload) begin
      bodc_d[src_pkg::BODC_EN] =
        user_configuration_word[src_pkg::CFG_BROWNOUT_ENABLE];
      bodc_d[src_pkg::BODC_RSTEN] =
        user_configuration_word[src_pkg::CFG_BORST];
      bodc_d[src_pkg::BODC_VL_LO +: 3] =
        user_configuration_word[src_pkg::CFG_BOV_LO +: 3];
    end
  end

  logic bs_q;
  logic cfg_init_q;
  logic [2:0] clksel_q;
  logic [3:0] clkdiv_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= SRC_HOLD;
      hold_q <= 8'(HOLD_CYC);
      core_only_q <= 1'b0;
      cause_q <= 9'h0_01;
      bodc_q <= src_pkg::BODC_RST;
      bs_q <= 1'b0;
      cfg_init_q <= 1'b1;
      clksel_q <= src_pkg::CLKSEL_RST;
      clkdiv_q <= src_pkg::CLKDIV_RST;
    end else begin
      st_q <= st_d;
      hold_q <= hold_d;
      core_only_q <= core_only_d;
      cause_q <= cause_d;
      cfg_init_q <= 1'b0;
      // configuration captured after release, never under reset
      if (cfg_init_q) begin
        bodc_q <= bodc_d;
        bodc_q[src_pkg::BODC_EN] <=
          user_configuration_word[src_pkg::CFG_BROWNOUT_ENABLE];
        bodc_q[src_pkg::BODC_RSTEN] <=
          user_configuration_word[src_pkg::CFG_BORST];
        bodc_q[src_pkg::BODC_VL_LO +: 3] <=
          user_configuration_word[src_pkg::CFG_BOV_LO +: 3];
      end else begin
        bodc_q <= bodc_d;
      end
      if (cfg_init_q || chip_class) begin
        bs_q <= user_configuration_word[src_pkg::CFG_BS];
      end else if (boot_select_we) begin
        bs_q <= boot_select_wdata;
      end
      // core-only reset leaves every setting alone
      if (full_any) begin
        clksel_q <= src_pkg::CLKSEL_RST;
        clkdiv_q <= div3_src ? src_pkg::CLKDIV_SOFT : src_pkg::CLKDIV_RST;
      end
    end
  end

  wire logic in_reset = (st_q != SRC_RUN);
  assign core_reset = in_reset;
  assign periph_reset = in_reset & ~core_only_q;
  assign reset_cause_register = cause_q;
  assign software_reset_control = 32'h0000_0000;  // self-clearing
  assign brownout_control_register = bodc_q;
  assign brownout_level_select = bodc_q[src_pkg::BODC_VL_LO +: 3];
  assign boot_select = bs_q;
  assign system_clock_source_select = clksel_q;
  assign system_clock_divider = clkdiv_q;
endmodule

// ---- verification/src_reset_ctrl_assertions.sv ----
// assertion checker for the system reset controller
`timescale 1ns/1ps
module src_reset_ctrl_chk #(
  parameter int PIN_CYC = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic external_reset_pin_n,
  input wire logic core_lockup,
  input wire logic debug_mode,
  input wire logic [31:0] user_configuration_word,
  input wire logic [31:0] software_reset_control_wdata,
  input wire logic software_reset_control_we,
  input wire logic [31:0] core_interrupt_reset_control_wdata,
  input wire logic core_interrupt_reset_control_we,
  input wire logic [8:0] cause_clear_wdata,
  input wire logic cause_clear_we,
  input wire logic boot_select_we,
  input wire logic core_reset,
  input wire logic periph_reset,
  input wire logic [8:0] reset_cause_register,
  input wire logic [31:0] brownout_control_register,
  input wire logic boot_select
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // raw pin run lengths; high count presumed long before power-up
  logic [15:0] lo_q, hi_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lo_q <= 16'h0000;
      hi_q <= 16'hFFFF;
    end else if (external_reset_pin_n) begin
      lo_q <= 16'h0000;
      hi_q <= hi_q + {15'h0000, hi_q != 16'hFFFF};
    end else begin
      lo_q <= lo_q + 16'h0001;
      hi_q <= 16'h0000;
    end
  end
  property p_core_only;
    software_reset_control_we && software_reset_control_wdata[1:0] == 2'h2
      && !periph_reset |=> core_reset && !periph_reset
      && reset_cause_register[7];
  endproperty
  a_core_only: assert property (p_core_only)
    else $error("core-only reset wrong");
  property p_chip;
    software_reset_control_we && software_reset_control_wdata[0]
      |=> core_reset && periph_reset && reset_cause_register[0];
  endproperty
  a_chip: assert property (p_chip)
    else $error("chip reset wrong");
  property p_sys;
    core_interrupt_reset_control_we && core_interrupt_reset_control_wdata[2]
      && !boot_select_we |=> periph_reset && reset_cause_register[5]
      && $stable(boot_select);
  endproperty
  a_sys: assert property (p_sys)
    else $error("system reset wrong");
  property p_lockup;
    (core_lockup && !debug_mode)[*5] |-> ##[0:3]
      (core_reset && reset_cause_register[8]);
  endproperty
  a_lockup: assert property (p_lockup)
    else $error("lockup reset missing");
  property p_lock_dbg;
    debug_mode[*4] |=> !$rose(reset_cause_register[8]);
  endproperty
  a_lock_dbg: assert property (p_lock_dbg)
    else $error("lockup not masked");
  property p_clr;
    cause_clear_we && !software_reset_control_we |=> reset_cause_register[0]
      == ($past(reset_cause_register[0]) & !$past(cause_clear_wdata[0]));
  endproperty
  a_clr: assert property (p_clr)
    else $error("power-on flag clear wrong");
  property p_bodc;
    $fell(sys_rst) |-> brownout_control_register[7]
      && brownout_control_register[14:12] == 3'h0;
  endproperty
  a_bodc: assert property (p_bodc)
    else $error("low-voltage defaults wrong");
  property p_cfg;
    $fell(sys_rst) |=> brownout_control_register[0]
      == user_configuration_word[19] && boot_select
      == user_configuration_word[1] && brownout_control_register[18:16]
      == user_configuration_word[23:21];
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("config reload wrong");
  property p_pin;
    $rose(reset_cause_register[1]) |-> $past(lo_q, 2) >= PIN_CYC;
  endproperty
  a_pin: assert property (p_pin)
    else $error("pin glitch accepted");
  property p_rel;
    $fell(periph_reset) |-> hi_q > PIN_CYC;
  endproperty
  a_rel: assert property (p_rel)
    else $error("released before pin settled");
  cover property (software_reset_control_we ##1 core_reset && !periph_reset);
  cover property ($rose(reset_cause_register[3]));
  cover property (debug_mode && core_lockup);
endmodule
bind src_reset_ctrl src_reset_ctrl_chk #(.PIN_CYC(PIN_CYC)) chk_u (
  .clk(clk), .sys_rst(sys_rst),
  .external_reset_pin_n(external_reset_pin_n),
  .core_lockup(core_lockup), .debug_mode(debug_mode),
  .user_configuration_word(user_configuration_word),
  .software_reset_control_wdata(software_reset_control_wdata),
  .software_reset_control_we(software_reset_control_we),
  .core_interrupt_reset_control_wdata(core_interrupt_reset_control_wdata),
  .core_interrupt_reset_control_we(core_interrupt_reset_control_we),
  .cause_clear_wdata(cause_clear_wdata), .cause_clear_we(cause_clear_we),
  .boot_select_we(boot_select_we), .core_reset(core_reset),
  .periph_reset(periph_reset), .reset_cause_register(reset_cause_register),
  .brownout_control_register(brownout_control_register),
  .boot_select(boot_select)
);

// ---- verification/src_partner.sv ----
// far-side model: reset pin, supply monitors and core status
`timescale 1ns/1ps
module src_partner (
  input wire logic clk,
  output logic external_reset_pin_n,
  output logic supply_ready,
  output logic low_voltage_ind,
  output logic brownout_ind,
  output logic core_lockup,
  output logic watchdog_reset
);
  // supply starts below ready, as on a real power ramp
  logic [5:0] act_q = 6'h02;
  assign external_reset_pin_n = !act_q[0];
  assign supply_ready = !act_q[1];
  assign low_voltage_ind = act_q[2];
  assign brownout_ind = act_q[3];
  assign core_lockup = act_q[4];
  assign watchdog_reset = act_q[5];
  task automatic set(input int sel, input logic v);
    @(negedge clk);
    act_q[sel] = v;
  endtask
  task automatic pulse(input int sel, input int n);
    set(sel, 1'b1);
    repeat (n) @(negedge clk);
    act_q[sel] = 1'b0;
  endtask
endmodule

// ---- verification/src_reset_ctrl_tb.sv ----
// self-checking bench for the system reset controller
`timescale 1ns/1ps
module src_reset_ctrl_tb;
  localparam int PIN = 8;
  localparam int NR = 8;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic debug_mode = 1'b0;
  logic [31:0] wd = '0;
  logic [4:0] we = '0;
  logic pin_n, sup, lv, brownout_detector, lock, wdt, core_reset, periph_reset, boot, busy;
  logic [8:0] cause;
  logic [31:0] swrc, bodc;
  logic [2:0] lvl, csel;
  logic [3:0] cdiv;
  int err_total = 0;
  int checks_done = 0;
  // row kind: 0..5 partner line, 6 chip, 7 core-only, 8 system request
  int kind [NR] = '{0, 5, 2, 3, 4, 6, 7, 8};
  logic [8:0] ecause [NR] = '{9'h002, 9'h004, 9'h008, 9'h010, 9'h100,
    9'h001, 9'h080, 9'h020};
  logic eper [NR] = '{1, 1, 1, 1, 1, 1, 0, 1};
  always #20 clk = ~clk;
  assign busy = core_reset | periph_reset;
  src_partner partner_u (.clk(clk), .external_reset_pin_n(pin_n),
    .supply_ready(sup), .low_voltage_ind(lv), .brownout_ind(brownout_detector),
    .core_lockup(lock), .watchdog_reset(wdt));
  src_reset_ctrl #(.PIN_CYC(PIN), .HOLD_CYC(4)) dut_u (.clk(clk),
    .sys_rst(sys_rst), .supply_ready(sup), .external_reset_pin_n(pin_n),
    .watchdog_reset(wdt), .low_voltage_ind(lv), .brownout_ind(brownout_detector),
    .core_lockup(lock), .debug_mode(debug_mode),
    .user_configuration_word(32'h0038_0000),
    .software_reset_control_wdata(wd), .software_reset_control_we(we[0]),
    .core_interrupt_reset_control_wdata(wd),
    .core_interrupt_reset_control_we(we[1]),
    .brownout_control_wdata(wd), .brownout_control_we(we[2]),
    .cause_clear_wdata(wd[8:0]), .cause_clear_we(we[3]),
    .boot_select_wdata(wd[0]), .boot_select_we(we[4]),
    .core_reset(core_reset), .periph_reset(periph_reset),
    .reset_cause_register(cause), .software_reset_control(swrc),
    .brownout_control_register(bodc), .brownout_level_select(lvl),
    .boot_select(boot), .system_clock_source_select(csel),
    .system_clock_divider(cdiv));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic wr(input int k, input logic [31:0] d);
    @(negedge clk);
    wd = d;
    we[k] = 1'b1;
    @(negedge clk);
    we = '0;
  endtask
  task automatic await(input logic v, input int n);
    for (int i = 0; i < n && busy !== v; i++) @(negedge clk);
    if (busy !== v) begin
      err_total++;
      final_report();
    end
  endtask
  task automatic clr();
    wr(3, 32'h0000_01FF);
    chk(cause, 9'h000);
  endtask
  task automatic fire(input int k);
    if (k == 0) partner_u.pulse(0, PIN + 6);
    else if (k < 6) partner_u.pulse(k, 6);
    else if (k == 8) wr(1, 32'h0000_0004);
    else wr(0, k - 5);
  endtask
  initial begin
    repeat (12) @(negedge clk);
    sys_rst = 1'b0;
    repeat (30) @(negedge clk);
    chk(core_reset, 1'b1);
    partner_u.set(1, 1'b0);
    await(1'b0, 100);
    chk(cause, 9'h001);
    chk(bodc, 32'h0001_0089);
    chk(lvl, 3'h1);
    chk(boot, 1'b0);
    chk({swrc[3:0], cdiv, 1'b0, csel}, 12'h005);
    wr(3, 32'h0000_0000);
    chk(cause, 9'h001);
    for (int r = 0; r < NR; r++) begin
      clr();
      fire(kind[r]);
      await(1'b1, 40);
      chk(periph_reset, eper[r]);
      await(1'b0, 100);
      chk(cause, ecause[r]);
    end
    clr();
    partner_u.pulse(0, PIN - 2);
    repeat (12) @(negedge clk);
    chk(busy, 1'b0);
    debug_mode = 1'b1;
    partner_u.pulse(4, 8);
    repeat (6) @(negedge clk);
    debug_mode = 1'b0;
    chk(cause, 9'h000);
    wr(2, 32'h0001_0009);
    partner_u.pulse(2, 6);
    repeat (6) @(negedge clk);
    chk(busy, 1'b0);
    wr(2, 32'h0001_1089);
    partner_u.pulse(2, 10);
    repeat (6) @(negedge clk);
    chk(busy, 1'b0);
    partner_u.pulse(2, 24);
    chk(busy, 1'b1);
    await(1'b0, 100);
    chk(cause, 9'h008);
    wr(4, 32'h0000_0001);
    fire(7);
    await(1'b1, 10);
    await(1'b0, 100);
    chk(boot, 1'b1);
    fire(8);
    await(1'b1, 10);
    await(1'b0, 100);
    chk({boot, cdiv}, 5'h13);
    fire(6);
    await(1'b1, 10);
    await(1'b0, 100);
    chk({boot, cdiv}, 5'h00);
    final_report();
  end
endmodule
